// [pkg/pma_consts.vh]
// register map, field positions and timing constants for the program memory access block
`ifndef PMA_CONSTS_VH
`define PMA_CONSTS_VH

// register indices on the plain register port
`define PMA_REG_CTRL      3'h0
`define PMA_REG_KEY       3'h1
`define PMA_REG_DATA_LO   3'h2
`define PMA_REG_DATA_HI   3'h3
`define PMA_REG_ADDR_LO   3'h4
`define PMA_REG_ADDR_HI   3'h5
`define PMA_REG_IRQ_STAT  3'h6
`define PMA_REG_IRQ_MASK  3'h7

// prog_mem_control bit positions
`define PMA_CTL_RD        0
`define PMA_CTL_WR        1
`define PMA_CTL_PERMIT    2
`define PMA_CTL_ABORT     3
`define PMA_CTL_ERASE     4

// interrupt status bit positions
`define PMA_IRQ_DONE      0
`define PMA_IRQ_SELF_REF  1
`define PMA_IRQ_PROG_REF  2
`define PMA_IRQ_W         3

// unlock key values
`define PMA_KEY_FIRST     8'h55
`define PMA_KEY_SECOND    8'haa

// self-write protect range codes
`define PMA_WRT_ALL       2'h0
`define PMA_WRT_HALF      2'h1
`define PMA_WRT_QUARTER   2'h2
`define PMA_WRT_OFF       2'h3

// erased word and word widths
`define PMA_ERASED        14'h3fff
`define PMA_DATA_W        14
`define PMA_ADDR_W        15
`define PMA_ID_N          4

// timing: write or erase time and core clock rate
`define PMA_T_OP_US       2000
`define PMA_CLK_MHZ       25

`endif

// [src/pma_op_timer.v]
// on-chip timer that sets the length of a write or erase operation
`timescale 1ns/10ps
`default_nettype none
module pma_op_timer #(
  parameter CW     = 16,
  parameter CYCLES = 50000
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          rst_b_i,
  // control
  input  wire          start_i,
  output reg           busy_o,
  output reg           done_o
);
  localparam [31:0]   LOAD_W = CYCLES - 1;
  localparam [CW-1:0] LOAD   = LOAD_W[CW-1:0];

  reg [CW-1:0] cnt_reg;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_reg <= {CW{1'b0}};
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        cnt_reg <= LOAD;
        busy_o  <= 1'b1;
      end else if (busy_o) begin
        if (cnt_reg == {CW{1'b0}}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end
endmodule // pma_op_timer
`default_nettype wire

// [src/pma_ctrl.v]
// program memory self-access controller with code and write protection
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pma_consts.vh"

// How it works
// - core reads and writes memory at run time
// - data register pair holds 14-bit word
// - address register pair holds 15-bit location
// - internal timer sets write and erase time
// - code protect refuses programmer memory reads, writes
// - code protect leaves self-write, erase working
// - only bulk erase clears code protect
// - range field blocks self-write and erase
// - range field never limits the programmer
// - start bits set-only, hardware clears them
// - 55h, AAh, then write-start, uninterrupted
// - writes need permit bit, clear after reset
// - reset during write sets abort flag
module pma_ctrl #(
  parameter IW        = 11,
  parameter ROW_W     = 4,
  parameter OP_CYCLES = `PMA_T_OP_US * `PMA_CLK_MHZ
) (
  // clock and reset
  input  wire                   clk_i,
  input  wire                   rst_b_i,
  // register port
  input  wire [2:0]             reg_addr_i,
  input  wire [7:0]             reg_wdata_i,
  input  wire                   reg_we_i,
  input  wire                   reg_re_i,
  output reg  [7:0]             reg_rdata_o,
  // external programmer port
  input  wire                   prog_rd_i,
  input  wire                   prog_wr_i,
  input  wire                   prog_id_sel_i,
  input  wire                   prog_cfg_wr_i,
  input  wire                   prog_bulk_i,
  input  wire [`PMA_ADDR_W-1:0] prog_addr_i,
  input  wire [`PMA_DATA_W-1:0] prog_wdata_i,
  output reg  [`PMA_DATA_W-1:0] prog_rdata_o,
  output reg                    prog_rvalid_o,
  output reg                    prog_refused_o,
  // status
  output reg                    busy_o,
  output reg                    irq_o
);
  localparam [1:0] KEY_IDLE  = 2'h0;
  localparam [1:0] KEY_GOT1  = 2'h1;
  localparam [1:0] KEY_ARMED = 2'h2;
  localparam       DEPTH     = 1 << IW;

  function wp_hit;
    input [1:0]    range;
    input [IW-1:0] idx;
    begin
      case (range)
        `PMA_WRT_ALL:     wp_hit = 1'b1;
        `PMA_WRT_HALF:    wp_hit = (idx[IW-1] == 1'b0);
        `PMA_WRT_QUARTER: wp_hit = (idx[IW-1:IW-2] == 2'h0);
        default:          wp_hit = 1'b0;
      endcase
    end
  endfunction

  // nonvolatile storage, deliberately not reset
  reg [`PMA_DATA_W-1:0] mem [0:DEPTH-1];
  reg [`PMA_DATA_W-1:0] id_mem [0:`PMA_ID_N-1];
  reg                   code_protect_n;
  reg [1:0]             self_write_protect_range;

  // software-visible registers
  reg [7:0]             prog_data_low_reg;
  reg [5:0]             prog_data_high_reg;
  reg [7:0]             prog_addr_low_reg;
  reg [6:0]             prog_addr_high_reg;
  reg                   rd_reg;
  reg                   write_permit_reg;
  reg                   write_abort_flag_reg;
  reg                   erase_sel_reg;
  reg [1:0]             key_state_reg;
  reg [`PMA_IRQ_W-1:0]  irq_stat_reg;
  reg [`PMA_IRQ_W-1:0]  irq_stat_next;
  reg [`PMA_IRQ_W-1:0]  irq_mask_reg;

  // operation state
  reg                   op_active_reg;
  reg                   op_active_next;
  reg                   erase_op_reg;
  reg                   walk_reg;
  reg                   bulk_reg;
  reg                   rst_seen_reg;
  reg [IW-1:0]          walk_idx_reg;
  reg [IW-1:0]          walk_last_reg;
  reg [7:0]             rd_mux;

  wire                  tmr_done;
  wire [`PMA_ADDR_W-1:0] addr_w = {prog_addr_high_reg, prog_addr_low_reg};
  wire [`PMA_DATA_W-1:0] data_w = {prog_data_high_reg, prog_data_low_reg};
  wire [IW-1:0]         idx_w   = addr_w[IW-1:0];
  wire [IW-1:0]         row_w   = {idx_w[IW-1:ROW_W], {ROW_W{1'b0}}};
  wire [IW-1:0]         pidx_w  = prog_addr_i[IW-1:0];
  wire                  busy_any = op_active_reg || walk_reg;

  wire ctl_wr   = reg_we_i && (reg_addr_i == `PMA_REG_CTRL);
  wire key_wr   = reg_we_i && (reg_addr_i == `PMA_REG_KEY);
  wire wr_req   = ctl_wr && reg_wdata_i[`PMA_CTL_WR] && !busy_any;
  wire erase_op_next_w = reg_wdata_i[`PMA_CTL_ERASE];
  // unlock, permit and range are all checked before anything starts
  wire wr_go    = wr_req && (key_state_reg == KEY_ARMED) && write_permit_reg &&
                  reg_wdata_i[`PMA_CTL_PERMIT];
  wire wr_start = wr_go && !wp_hit(self_write_protect_range,
                                   erase_op_next_w ? row_w : idx_w);
  wire self_ref = wr_req && !wr_start;
  wire walk_end = walk_reg && (walk_idx_reg == walk_last_reg);
  wire op_end   = (tmr_done && !erase_op_reg) || (walk_end && !bulk_reg);
  wire bulk_go  = rst_b_i && prog_bulk_i && !busy_any;
  // code protection only gates the programmer path
  wire prog_mem = !prog_id_sel_i;
  wire prog_ok  = code_protect_n || !prog_mem;
  wire prog_wr_ok = rst_b_i && prog_wr_i && prog_ok && !busy_any;
  wire prog_ref = (prog_rd_i || prog_wr_i) && !prog_ok;

  pma_op_timer #(
    .CW     (17),
    .CYCLES (OP_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .start_i (wr_start),
    .busy_o  (),
    .done_o  (tmr_done)
  );

  // memory, ids and configuration word
  always @(posedge clk_i) begin
    if (walk_reg) begin
      mem[walk_idx_reg] <= `PMA_ERASED;
    end else if (tmr_done && !erase_op_reg) begin
      mem[idx_w] <= data_w;
    end else if (prog_wr_ok && prog_mem) begin
      mem[pidx_w] <= prog_wdata_i;
    end
    if (prog_wr_ok && !prog_mem) begin
      id_mem[prog_addr_i[1:0]] <= prog_wdata_i;
    end
    if (bulk_go) begin
      code_protect_n           <= 1'b1;
      self_write_protect_range <= `PMA_WRT_OFF;
      id_mem[0]                <= `PMA_ERASED;
      id_mem[1]                <= `PMA_ERASED;
      id_mem[2]                <= `PMA_ERASED;
      id_mem[3]                <= `PMA_ERASED;
    end else if (rst_b_i && prog_cfg_wr_i && !busy_any) begin
      // flash cells only program towards zero
      code_protect_n           <= code_protect_n & prog_wdata_i[2];
      self_write_protect_range <= self_write_protect_range & prog_wdata_i[1:0];
    end
  end

  always @* begin
    op_active_next = op_active_reg;
    if (wr_start) begin
      op_active_next = 1'b1;
    end else if (op_end) begin
      op_active_next = 1'b0;
    end
    irq_stat_next = irq_stat_reg;
    if (reg_re_i && (reg_addr_i == `PMA_REG_IRQ_STAT)) begin
      irq_stat_next = {`PMA_IRQ_W{1'b0}};
    end
    // a new event wins over the read clear
    if (op_end) begin
      irq_stat_next[`PMA_IRQ_DONE] = 1'b1;
    end
    if (self_ref) begin
      irq_stat_next[`PMA_IRQ_SELF_REF] = 1'b1;
    end
    if (prog_ref) begin
      irq_stat_next[`PMA_IRQ_PROG_REF] = 1'b1;
    end
    case (reg_addr_i)
      `PMA_REG_CTRL:     rd_mux = {3'h0, erase_sel_reg, write_abort_flag_reg,
                                   write_permit_reg, op_active_reg, rd_reg};
      `PMA_REG_DATA_LO:  rd_mux = prog_data_low_reg;
      `PMA_REG_DATA_HI:  rd_mux = {2'h0, prog_data_high_reg};
      `PMA_REG_ADDR_LO:  rd_mux = prog_addr_low_reg;
      `PMA_REG_ADDR_HI:  rd_mux = {1'h0, prog_addr_high_reg};
      `PMA_REG_IRQ_STAT: rd_mux = {5'h0, irq_stat_reg};
      `PMA_REG_IRQ_MASK: rd_mux = {5'h0, irq_mask_reg};
      default:           rd_mux = 8'h00; // key register reads zero
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      prog_data_low_reg    <= 8'h00;
      prog_data_high_reg   <= 6'h00;
      prog_addr_low_reg    <= 8'h00;
      prog_addr_high_reg   <= 7'h00;
      rd_reg               <= 1'b0;
      write_permit_reg     <= 1'b0;
      // an abort caught on the first reset cycle survives a long reset
      if (op_active_reg || walk_reg || rst_seen_reg) begin
        write_abort_flag_reg <= write_abort_flag_reg | op_active_reg | walk_reg;
      end else begin
        write_abort_flag_reg <= 1'b0;
      end
      rst_seen_reg         <= 1'b1;
      erase_sel_reg        <= 1'b0;
      key_state_reg        <= KEY_IDLE;
      irq_stat_reg         <= {`PMA_IRQ_W{1'b0}};
      irq_mask_reg         <= {`PMA_IRQ_W{1'b0}};
      op_active_reg        <= 1'b0;
      erase_op_reg         <= 1'b0;
      walk_reg             <= 1'b0;
      bulk_reg             <= 1'b0;
      walk_idx_reg         <= {IW{1'b0}};
      walk_last_reg        <= {IW{1'b0}};
      reg_rdata_o          <= 8'h00;
      prog_rdata_o         <= {`PMA_DATA_W{1'b0}};
      prog_rvalid_o        <= 1'b0;
      prog_refused_o       <= 1'b0;
      busy_o               <= 1'b0;
      irq_o                <= 1'b0;
    end else begin
      reg_rdata_o <= reg_re_i ? rd_mux : 8'h00;
      rst_seen_reg <= 1'b0;
      // unlock sequence: any other write breaks it
      if (key_wr && (reg_wdata_i == `PMA_KEY_FIRST)) begin
        key_state_reg <= KEY_GOT1;
      end else if (key_wr && (key_state_reg == KEY_GOT1) &&
                   (reg_wdata_i == `PMA_KEY_SECOND)) begin
        key_state_reg <= KEY_ARMED;
      end else if (reg_we_i) begin
        key_state_reg <= KEY_IDLE;
      end
      if (ctl_wr) begin
        write_permit_reg     <= reg_wdata_i[`PMA_CTL_PERMIT];
        write_abort_flag_reg <= write_abort_flag_reg & reg_wdata_i[`PMA_CTL_ABORT];
        if (!busy_any) begin
          erase_sel_reg <= reg_wdata_i[`PMA_CTL_ERASE];
        end
      end
      // read takes one cycle, then the bit self-clears
      if (rd_reg) begin
        rd_reg             <= 1'b0;
        prog_data_low_reg  <= mem[idx_w][7:0];
        prog_data_high_reg <= mem[idx_w][13:8];
      end else begin
        if (ctl_wr && reg_wdata_i[`PMA_CTL_RD] && !busy_any) begin
          rd_reg <= 1'b1;
        end
        if (reg_we_i && (reg_addr_i == `PMA_REG_DATA_LO)) begin
          prog_data_low_reg <= reg_wdata_i;
        end
        if (reg_we_i && (reg_addr_i == `PMA_REG_DATA_HI)) begin
          prog_data_high_reg <= reg_wdata_i[5:0];
        end
      end
      if (reg_we_i && (reg_addr_i == `PMA_REG_ADDR_LO) && !busy_any) begin
        prog_addr_low_reg <= reg_wdata_i;
      end
      if (reg_we_i && (reg_addr_i == `PMA_REG_ADDR_HI) && !busy_any) begin
        prog_addr_high_reg <= reg_wdata_i[6:0];
      end
      if (reg_we_i && (reg_addr_i == `PMA_REG_IRQ_MASK)) begin
        irq_mask_reg <= reg_wdata_i[`PMA_IRQ_W-1:0];
      end
      irq_stat_reg  <= irq_stat_next;
      irq_o         <= |(irq_stat_next & irq_mask_reg);
      op_active_reg <= op_active_next;
      if (wr_start) begin
        erase_op_reg <= erase_op_next_w;
      end
      // row or bulk erase walks the array one word a cycle
      if (tmr_done && erase_op_reg) begin
        walk_reg      <= 1'b1;
        bulk_reg      <= 1'b0;
        walk_idx_reg  <= row_w;
        walk_last_reg <= row_w | {{(IW-ROW_W){1'b0}}, {ROW_W{1'b1}}};
      end else if (bulk_go) begin
        walk_reg      <= 1'b1;
        bulk_reg      <= 1'b1;
        walk_idx_reg  <= {IW{1'b0}};
        walk_last_reg <= {IW{1'b1}};
      end else if (walk_end) begin
        walk_reg <= 1'b0;
        bulk_reg <= 1'b0;
      end else if (walk_reg) begin
        walk_idx_reg <= walk_idx_reg + 1'b1;
      end
      busy_o         <= op_active_next || (walk_reg && !walk_end) || bulk_go;
      prog_rvalid_o  <= prog_rd_i && prog_ok;
      prog_refused_o <= prog_ref;
      if (prog_rd_i && prog_ok) begin
        prog_rdata_o <= prog_mem ? mem[pidx_w] : id_mem[prog_addr_i[1:0]];
      end
    end
  end
endmodule // pma_ctrl
`default_nettype wire

// [src/pma_ctrl_unused_placeholder_none.v]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [tb/pma_ctrl_sva.sv]
// port-level assertions for the program memory access block
`timescale 1ns/10ps
`default_nettype none
module pma_ctrl_sva #(
  parameter IW        = 11,
  parameter ROW_W     = 4,
  parameter OP_CYCLES = 50000
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // register port
  input wire logic [2:0]  reg_addr_i,
  input wire logic        reg_we_i,
  input wire logic        reg_re_i,
  input wire logic [7:0]  reg_rdata_o,
  // programmer port and status
  input wire logic        prog_rd_i,
  input wire logic        prog_wr_i,
  input wire logic        prog_id_sel_i,
  input wire logic        prog_bulk_i,
  input wire logic [13:0] prog_rdata_o,
  input wire logic        prog_rvalid_o,
  input wire logic        prog_refused_o,
  input wire logic        busy_o,
  input wire logic        irq_o
);
  localparam LIM = OP_CYCLES + 2**ROW_W + 2**IW + 4;
  logic [31:0] run_reg;
  logic        bulk_reg;
  // busy length and whether a bulk erase began it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      run_reg  <= 32'h0000_0000;
      bulk_reg <= 1'b0;
    end else begin
      run_reg  <= busy_o ? run_reg + 32'h0000_0001 : 32'h0000_0000;
      bulk_reg <= busy_o ? bulk_reg : prog_bulk_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_slot; reg_rdata_o != 8'h00 |-> $past(reg_re_i); endproperty
  a_slot: assert property (p_slot) else $error("rdata slot");
  property p_key; $past(reg_re_i && reg_addr_i == 3'h1) |-> reg_rdata_o == 8'h00; endproperty
  a_key: assert property (p_key) else $error("key read");
  property p_start; $rose(busy_o) |-> $past(reg_we_i && reg_addr_i == 3'h0) || $past(prog_bulk_i);
  endproperty
  a_start: assert property (p_start) else $error("busy cause");
  property p_tmin; $fell(busy_o) |-> run_reg >= (bulk_reg ? 2**IW : OP_CYCLES); endproperty
  a_tmin: assert property (p_tmin) else $error("op short");
  property p_tmax; busy_o |-> run_reg < LIM; endproperty
  a_tmax: assert property (p_tmax) else $error("op long");
  property p_rv; prog_rvalid_o |-> $past(prog_rd_i); endproperty
  a_rv: assert property (p_rv) else $error("rvalid cause");
  property p_ref; prog_refused_o |-> $past((prog_rd_i || prog_wr_i) && !prog_id_sel_i); endproperty
  a_ref: assert property (p_ref) else $error("refuse cause");
  property p_ans; prog_rd_i && !busy_o |=> prog_rvalid_o ^ prog_refused_o; endproperty
  a_ans: assert property (p_ans) else $error("read answer");
  property p_hold; !prog_rvalid_o |-> $stable(prog_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("rdata hold");
  property p_quiet; $rose(rst_b_i) |-> !busy_o && !irq_o; endproperty
  a_quiet: assert property (p_quiet) else $error("reset quiet");
  c_op: cover property ($rose(busy_o));
  c_ref: cover property (prog_refused_o);
  c_irq: cover property (irq_o);
endmodule // pma_ctrl_sva
bind pma_ctrl pma_ctrl_sva #(.IW(IW), .ROW_W(ROW_W), .OP_CYCLES(OP_CYCLES)) pma_ctrl_sva_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .prog_rd_i(prog_rd_i), .prog_wr_i(prog_wr_i),
  .prog_id_sel_i(prog_id_sel_i), .prog_bulk_i(prog_bulk_i), .prog_rdata_o(prog_rdata_o),
  .prog_rvalid_o(prog_rvalid_o), .prog_refused_o(prog_refused_o), .busy_o(busy_o),
  .irq_o(irq_o));
`default_nettype wire

// [tb/pma_prog_model.sv]
// external programmer model on the programmer port
`timescale 1ns/10ps
`default_nettype none
module pma_prog_model (
  // clock
  input wire logic        clk_i,
  // commands {bulk, cfg, wr, rd} and payload
  output var logic [3:0]  cmd_o,
  output var logic        id_sel_o,
  output var logic [14:0] addr_o,
  output var logic [13:0] wdata_o,
  // answers
  input wire logic [13:0] rdata_i,
  input wire logic        rvalid_i,
  input wire logic        refused_i
);
  initial begin
    cmd_o = 4'h0;
    id_sel_o = 1'b0;
    addr_o = 15'h0000;
    wdata_o = 14'h0000;
  end
  // one-cycle command; payload inverted afterwards so stale data never matches
  task op(input [3:0] k, input id, input [14:0] a, input [13:0] d,
          output [13:0] q, output [1:0] ans);
    @(posedge clk_i);
    cmd_o    <= k;
    id_sel_o <= id;
    addr_o   <= a;
    wdata_o  <= d;
    @(posedge clk_i);
    cmd_o   <= 4'h0;
    addr_o  <= ~a;
    wdata_o <= ~d;
    @(negedge clk_i);
    q   = rdata_i;
    ans = {rvalid_i, refused_i};
  endtask
endmodule // pma_prog_model
`default_nettype wire

// [tb/pma_ctrl_tb.sv]
// self-checking testbench for the program memory access block
`timescale 1ns/10ps
`default_nettype none
`include "pma_consts.vh"
module pma_ctrl_tb;
  localparam OP = 20;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [2:0]  reg_addr_i = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [7:0]  reg_rdata_o, v;
  logic [3:0]  cmd;
  logic        id_sel, prvalid, prefused, busy_o, irq_o;
  logic [14:0] paddr;
  logic [13:0] pwdata, prdata, q;
  logic [1:0]  ans;
  logic [13:0] cfg_t [5] = '{14'h0006, 14'h0006, 14'h0004, 14'h0005, 14'h0005};
  logic [14:0] adr_t [5] = '{15'h0000, 15'h0010, 15'h003f, 15'h001f, 15'h0020};
  logic [4:0]  ok_t = 5'h12;
  int          n_errors = 0;
  int          comparisons = 0;
  always #20 clk_i = ~clk_i;
  pma_ctrl #(.IW(6), .ROW_W(4), .OP_CYCLES(OP)) pma_ctrl_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .prog_rd_i(cmd[0]), .prog_wr_i(cmd[1]), .prog_id_sel_i(id_sel), .prog_cfg_wr_i(cmd[2]),
    .prog_bulk_i(cmd[3]), .prog_addr_i(paddr), .prog_wdata_i(pwdata), .prog_rdata_o(prdata),
    .prog_rvalid_o(prvalid), .prog_refused_o(prefused), .busy_o(busy_o), .irq_o(irq_o));
  pma_prog_model pma_prog_model_i (.clk_i(clk_i), .cmd_o(cmd), .id_sel_o(id_sel),
    .addr_o(paddr), .wdata_o(pwdata), .rdata_i(prdata), .rvalid_i(prvalid),
    .refused_i(prefused));
  task final_report;
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  task rd(input [2:0] a);
    @(posedge clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(negedge clk_i);
    v = reg_rdata_o;
  endtask
  task po(input [3:0] k, input id, input [14:0] a, input [13:0] d);
    pma_prog_model_i.op(k, id, a, d, q, ans);
  endtask
  task waitb(output int n);
    n = 0;
    while (busy_o === 1'b1 && n < 9999) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task bulk;
    int n;
    po(4'h8, 1'b0, 15'h0000, 14'h0000);
    waitb(n);
    chk("bulk time", n + 1 >= 64, 1'b1);
  endtask
  task sr(input [14:0] a, input [13:0] e);
    logic [7:0] lo;
    wr(`PMA_REG_ADDR_LO, a[7:0]);
    wr(`PMA_REG_ADDR_HI, {1'b0, a[14:8]});
    wr(`PMA_REG_CTRL, 8'h01);
    repeat (2) @(posedge clk_i);
    rd(`PMA_REG_DATA_LO);
    lo = v;
    rd(`PMA_REG_DATA_HI);
    chk("self read", {v[5:0], lo}, e);
  endtask
  task sw(input [14:0] a, input [13:0] d, input [7:0] c, input ok);
    int n;
    wr(`PMA_REG_ADDR_LO, a[7:0]);
    wr(`PMA_REG_ADDR_HI, {1'b0, a[14:8]});
    wr(`PMA_REG_DATA_LO, d[7:0]);
    wr(`PMA_REG_DATA_HI, {2'b00, d[13:8]});
    wr(`PMA_REG_CTRL, 8'h04);
    wr(`PMA_REG_KEY, `PMA_KEY_FIRST);
    wr(`PMA_REG_KEY, `PMA_KEY_SECOND);
    wr(`PMA_REG_CTRL, c);
    @(negedge clk_i);
    chk("busy", busy_o, ok);
    waitb(n);
    chk("op time", n + 1 >= OP, ok);
    rd(`PMA_REG_IRQ_STAT);
    chk("status", v[1:0], ok ? 2'h1 : 2'h2);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(`PMA_REG_CTRL);
    chk("ctrl", v[4:0], 5'h00);
    rd(`PMA_REG_KEY);
    chk("key", v, 8'h00);
    bulk();
    po(4'h2, 1'b0, 15'h0005, 14'h1234);
    po(4'h1, 1'b0, 15'h0005, 14'h0000);
    chk("prog read", {ans, q}, {2'b10, 14'h1234});
    po(4'h4, 1'b0, 15'h0000, 14'h0003);
    po(4'h1, 1'b0, 15'h0005, 14'h0000);
    chk("locked read", ans, 2'b01);
    po(4'h2, 1'b0, 15'h0005, 14'h0bad);
    chk("locked write", ans, 2'b01);
    po(4'h1, 1'b1, 15'h0000, 14'h0000);
    chk("user id", {ans, q}, {2'b10, `PMA_ERASED});
    sr(15'h0005, 14'h1234);
    sw(15'h0007, 14'h2bcd, 8'h06, 1'b1);
    sr(15'h0007, 14'h2bcd);
    rd(`PMA_REG_CTRL);
    chk("start bits", v[1:0], 2'b00);
    sw(15'h0009, 14'h0001, 8'h02, 1'b0);
    wr(`PMA_REG_IRQ_MASK, 8'h00);
    wr(`PMA_REG_CTRL, 8'h04);
    wr(`PMA_REG_KEY, `PMA_KEY_FIRST);
    wr(`PMA_REG_DATA_LO, 8'h00);
    wr(`PMA_REG_KEY, `PMA_KEY_SECOND);
    wr(`PMA_REG_CTRL, 8'h06);
    @(negedge clk_i);
    chk("broken unlock", {busy_o, irq_o}, 2'b00);
    wr(`PMA_REG_IRQ_MASK, 8'h02);
    repeat (2) @(negedge clk_i);
    chk("irq up", irq_o, 1'b1);
    rd(`PMA_REG_IRQ_STAT);
    chk("irq status", v[1:0], 2'h2);
    chk("irq down", irq_o, 1'b0);
    bulk();
    po(4'h1, 1'b0, 15'h0005, 14'h0000);
    chk("cp cleared", {ans, q}, {2'b10, `PMA_ERASED});
    for (int i = 0; i < 5; i++) begin
      if (i == 3) bulk();
      po(4'h4, 1'b0, 15'h0000, cfg_t[i]);
      sw(adr_t[i], 14'h0123, 8'h06, ok_t[i]);
    end
    sr(15'h001f, `PMA_ERASED);
    po(4'h2, 1'b0, 15'h001f, 14'h0abc);
    po(4'h1, 1'b0, 15'h001f, 14'h0000);
    chk("prog under wp", {ans, q}, {2'b10, 14'h0abc});
    sw(15'h0020, 14'h0000, 8'h16, 1'b1);
    sr(15'h0020, `PMA_ERASED);
    wr(`PMA_REG_CTRL, 8'h04);
    wr(`PMA_REG_KEY, `PMA_KEY_FIRST);
    wr(`PMA_REG_KEY, `PMA_KEY_SECOND);
    wr(`PMA_REG_CTRL, 8'h06);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(`PMA_REG_CTRL);
    chk("abort", v[3:2], 2'b10);
    wr(`PMA_REG_CTRL, 8'h00);
    rd(`PMA_REG_CTRL);
    chk("abort clear", v[3], 1'b0);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    final_report();
  end
endmodule // pma_ctrl_tb
`default_nettype wire
